// *** dv/pei_fmt_model.sv ***
// Formatter model: sends T1 frames of zero bits and judges the returned stream.
// Assumes 193-bit frames, framing bit first, odd channels marked as selected.
`timescale 1ns/1ps

module pei_fmt_model
    import pei_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [3:0] nframes,
    input wire logic sel_on,
    input wire logic stall,
    input wire logic tx_in_ready,
    input wire pei_bit_t tx_out,
    input wire logic tx_out_valid,
    output pei_bit_t tx_in,
    output logic tx_in_valid,
    output logic tx_out_ready,
    output logic done,
    output logic [15:0] n_inv,
    output logic [15:0] n_bad,
    output logic [15:0] first_at,
    output logic saw_full
);
    // ----------------------------------------
    // Frame position and line drive
    // ----------------------------------------
    logic [15:0] sent_reg, got_reg, elig_reg, total;
    logic sending_reg, cyc_reg, elig;
    logic [7:0] pos_in, pos_out, pm1;
    assign total = 16'(nframes) * 16'd193;
    assign pos_in = 8'(sent_reg % 16'd193);
    assign pos_out = 8'(got_reg % 16'd193);
    assign pm1 = pos_in - 8'd1;
    // Idle line toggles so a stale bit never looks like fresh data
    assign tx_in = sending_reg ? {1'b0, pos_in == 8'h00, pos_in == 8'h00, pm1[3]} : {4{cyc_reg}};
    assign tx_in_valid = sending_reg;
    assign tx_out_ready = !(stall && cyc_reg); // Half-rate sink fills the buffer
    assign done = !sending_reg && (got_reg == total);
    assign elig = (pos_out != 8'h00) && (!sel_on || tx_out.chan_sel);

    // ----------------------------------------
    // Source and sink bookkeeping
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {sent_reg, got_reg, elig_reg, n_inv, n_bad, first_at} <= '0;
            {sending_reg, cyc_reg, saw_full} <= '0;
        end else begin
            cyc_reg <= !cyc_reg;
            if (start) begin
                {sent_reg, got_reg, elig_reg, n_inv, n_bad, first_at} <= '0;
                sending_reg <= 1'b1;
            end else begin
                if (sending_reg && !tx_in_ready) saw_full <= 1'b1;
                if (tx_in_valid && tx_in_ready) begin
                    sent_reg <= sent_reg + 16'd1;
                    if (sent_reg == total - 16'd1) sending_reg <= 1'b0;
                end
                if (tx_out_valid && tx_out_ready) begin
                    got_reg <= got_reg + 16'd1;
                    if (!elig && tx_out.data) n_bad <= n_bad + 16'd1;
                    if (elig) elig_reg <= elig_reg + 16'd1;
                    if (elig && tx_out.data) begin
                        n_inv <= n_inv + 16'd1;
                        if (n_inv == 16'd0) first_at <= elig_reg + 16'd1;
                    end
                end
            end
        end
    end
endmodule

// *** dv/pei_top_tb.sv ***
// Self-checking bench for the payload error inserter: APB master plus formatter model.
// Assumes zero-wait APB answers and the frame layout of the formatter model.
`timescale 1ns/1ps
`include "pei_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

module pei_top_tb
    import pei_pkg::*;
;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rdata;
    pei_bit_t tx_in, tx_out;
    logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready, done, saw_full;
    logic start = 0, sel_on = 0, stall = 0;
    logic [3:0] nframes = '0;
    logic [15:0] n_inv, n_bad, first_at;
    int n_errors = 0, n_compared = 0;
    pei_top uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_in(tx_in),
        .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_out(tx_out), .tx_out_valid(tx_out_valid),
        .tx_out_ready(tx_out_ready));
    pei_fmt_model fmt (.core_clk(core_clk), .rst_n(rst_n), .start(start), .nframes(nframes), .sel_on(sel_on),
        .stall(stall), .tx_in_ready(tx_in_ready), .tx_out(tx_out), .tx_out_valid(tx_out_valid), .tx_in(tx_in),
        .tx_in_valid(tx_in_valid), .tx_out_ready(tx_out_ready), .done(done), .n_inv(n_inv), .n_bad(n_bad),
        .first_at(first_at), .saw_full(saw_full));
    initial begin
        forever #2.5 core_clk = !core_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int i;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, 22'h0, idx, 2'b00, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge core_clk); i++; end while (pready !== 1'b1 && i < 50);
        {rdata, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (i >= 50) begin n_errors++; conclude(); end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, '0);
        `CHK({err, rdata}, {25'h0, exp})
    endtask
    task automatic reset_all();
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask
    task automatic run(input logic [3:0] nf, input logic sel, input logic st);
        int i;
        @(posedge core_clk);
        {nframes, sel_on, stall, start} <= {nf, sel, st, 1'b1};
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
        for (i = 0; i < 6000 && done !== 1'b1; i++) @(posedge core_clk);
        if (i >= 6000) begin n_errors++; conclude(); end
    endtask
    task automatic setup(input logic [7:0] mode, input logic [7:0] rate);
        reset_all();
        apb(1'b1, `PEI_IDX_MODE_CTRL, {24'h0, mode});
        apb(1'b1, `PEI_IDX_RATE_CTRL, {24'h0, rate}); // Callers keep bits 6:5 at zero
    endtask
    task automatic load(input logic [9:0] n);
        apb(1'b1, `PEI_IDX_CNT_LO, {24'h0, n[7:0]});
        apb(1'b1, `PEI_IDX_CNT_HI, {30'h0, n[9:8]});
        apb(1'b1, `PEI_IDX_RATE_CTRL, 32'h01); // Load bit low first, then raised
        apb(1'b1, `PEI_IDX_RATE_CTRL, 32'h81);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        int r;
        reset_all();
        for (r = 'heb; r <= 'hef; r++) rd(8'(r), 8'h00);
        apb(1'b1, `PEI_IDX_LEFT_LO, 32'hff);
        rd(`PEI_IDX_LEFT_LO, 8'h00);
        apb(1'b0, 8'h10, '0);
        `CHK(err, 1'b1)
    endtask
    task automatic t_t1_off();
        setup(8'h00, 8'h11);
        run(4'd1, 1'b0, 1'b0);
        `CHK(n_inv, 16'd0)
    endtask
    task automatic t_rates();
        int k;
        for (k = 1; k <= 3; k++) begin
            setup(8'h01, 8'(8'h10 | k));
            run(4'd2, 1'b0, k == 1);
            `CHK(n_inv, 16'(384 >> (k + 3)))
            `CHK(first_at, 16'(1 << (k + 3)))
            `CHK(n_bad, 16'd0)
            if (k == 1) `CHK(saw_full, 1'b1)
        end
    endtask
    task automatic t_zero_rate();
        setup(8'h01, 8'h10);
        run(4'd1, 1'b0, 1'b0);
        `CHK(n_inv, 16'd0)
    endtask
    task automatic t_counted();
        setup(8'h01, 8'h01);
        load(10'd5);
        rd(`PEI_IDX_LEFT_LO, 8'h05);
        run(4'd1, 1'b0, 1'b1);
        `CHK(n_inv, 16'd5)
        rd(`PEI_IDX_LEFT_LO, 8'h00);
        load(10'd0);
        run(4'd1, 1'b0, 1'b0);
        `CHK(n_inv, 16'd0)
        load(10'h3ff);
        rd(`PEI_IDX_LEFT_HI, 8'h03);
        rd(`PEI_IDX_LEFT_LO, 8'hff);
    endtask
    task automatic t_chsel();
        setup(8'h03, 8'h11);
        run(4'd2, 1'b1, 1'b0);
        `CHK(n_inv, 16'd12)
        `CHK(n_bad, 16'd0)
    endtask
    task automatic t_rate_change();
        setup(8'h01, 8'h10);
        fork
            run(4'd2, 1'b0, 1'b0);
            begin repeat (60) @(posedge core_clk); apb(1'b1, `PEI_IDX_RATE_CTRL, 32'h11); end
        join
        `CHK(n_inv, 16'd12)
        `CHK(first_at, 16'd208)
    endtask

    initial begin
        reset_all();
        t_regs();
        t_t1_off();
        t_rates();
        t_zero_rate();
        t_counted();
        t_chsel();
        t_rate_change();
        conclude();
    end
endmodule

// *** include/pei_params.svh ***
// Constants for the T1 payload error inserter: register indices, fields, resets.
// Assumes an APB slave with one 32-bit word per register, byte address = 4 * index.
`ifndef PEI_PARAMS_SVH
`define PEI_PARAMS_SVH

// Register indices
`define PEI_IDX_RATE_CTRL 8'heb
`define PEI_IDX_CNT_LO 8'hec
`define PEI_IDX_CNT_HI 8'hed
`define PEI_IDX_LEFT_LO 8'hee
`define PEI_IDX_LEFT_HI 8'hef
`define PEI_IDX_MODE_CTRL 8'hf0

// Fields of the rate control register
`define PEI_RATE_LSB 0
`define PEI_CONST_BIT 4
`define PEI_LOAD_BIT 7
`define PEI_RATE_CTRL_MASK 8'h9f

// Fields of the mode control register
`define PEI_T1_BIT 0
`define PEI_CHSEL_BIT 1

// Reset value, rate shift and buffer depth
`define PEI_RESET_BYTE 8'h00
`define PEI_RATE_SHIFT 5'h03
`define PEI_FIFO_DEPTH 8

`endif

// *** include/pei_pkg.sv ***
// Types shared by the payload error inserter and its surroundings.
// Assumes the transmit formatter marks framing bits and frame starts per bit.
package pei_pkg;

    // One transmit bit with its position markers
    typedef struct packed {
        logic data;
        logic fbit;
        logic frame_start;
        logic chan_sel;
    } pei_bit_t;

    typedef logic [3:0] pei_rate_t;
    typedef logic [9:0] pei_count_t;

endpackage

// *** logic/pei_top.sv ***
// Payload error inserter with its APB register slave and input FIFO.
// Assumes the formatter stream and APB run on core_clk; all bit markers are synchronous.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "pei_params.svh"

// ----------------------------------------
// Bit FIFO
// ----------------------------------------
module pei_fifo
    import pei_pkg::*;
#(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Extra pointer bit tells full from empty
    assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    // Storage has no reset; only the pointers matter
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end

    // ----------------------------------------
    // Buffer assertions
    // ----------------------------------------
    // Occupancy never exceeds the depth; a wrong full flag would let a push
    // overwrite the oldest unread bit and silently reorder the stream
    a_fifo_depth: assert property (@(posedge core_clk) disable iff (!rst_n)
        (AW+1)'(wr_ptr_reg - rd_ptr_reg) <= (AW+1)'(DEPTH))
        else $error("bit buffer overfilled");
endmodule

// ----------------------------------------
// Inserter top
// ----------------------------------------
module pei_top
    import pei_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pei_bit_t tx_in,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    output pei_bit_t tx_out,
    output logic tx_out_valid,
    input wire logic tx_out_ready
);
    // Last bit of a counting period for rate k: period is 2^(k+3)
    function automatic logic period_end(input logic [17:0] cnt, input pei_rate_t rate);
        logic [17:0] last;
        last = 18'((18'h00001 << (5'(rate) + `PEI_RATE_SHIFT)) - 18'h00001);
        return cnt == last;
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic [7:0] rate_ctrl_reg;
    logic [7:0] cnt_lo_reg;
    logic [1:0] cnt_hi_reg;
    logic [1:0] mode_ctrl_reg;
    pei_count_t left_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    wire [7:0] idx = paddr[9:2];
    wire addr_ok = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
    wire hit_rate = addr_ok && idx == `PEI_IDX_RATE_CTRL;
    wire hit_lo = addr_ok && idx == `PEI_IDX_CNT_LO;
    wire hit_hi = addr_ok && idx == `PEI_IDX_CNT_HI;
    wire hit_left_lo = addr_ok && idx == `PEI_IDX_LEFT_LO;
    wire hit_left_hi = addr_ok && idx == `PEI_IDX_LEFT_HI;
    wire hit_mode = addr_ok && idx == `PEI_IDX_MODE_CTRL;
    wire hit_any = hit_rate | hit_lo | hit_hi | hit_left_lo | hit_left_hi | hit_mode;
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pready_reg & pwrite & hit_any;

    // Remaining count is read live, so software sees it at any moment
    wire [7:0] rd_byte =
        hit_rate ? rate_ctrl_reg :
        hit_lo ? cnt_lo_reg :
        hit_hi ? {6'h00, cnt_hi_reg} :
        hit_left_lo ? left_reg[7:0] :
        hit_left_hi ? {6'h00, left_reg[9:8]} :
        hit_mode ? {6'h00, mode_ctrl_reg} : `PEI_RESET_BYTE;

    // Answer is prepared in setup, so access lasts exactly one cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit_any;
            prdata_reg <= setup & ~pwrite ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // Register writes; unused rate bits are kept at zero in case software slips
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_ctrl_reg <= `PEI_RESET_BYTE;
            cnt_lo_reg <= `PEI_RESET_BYTE;
            cnt_hi_reg <= 2'h0;
            mode_ctrl_reg <= 2'h0;
        end else if (wr_en) begin
            if (hit_rate) rate_ctrl_reg <= pwdata[7:0] & `PEI_RATE_CTRL_MASK;
            if (hit_lo) cnt_lo_reg <= pwdata[7:0];
            if (hit_hi) cnt_hi_reg <= pwdata[1:0];
            if (hit_mode) mode_ctrl_reg <= pwdata[1:0];
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    wire pei_rate_t rate_field = rate_ctrl_reg[`PEI_RATE_LSB +: 4];
    wire const_mode = rate_ctrl_reg[`PEI_CONST_BIT];
    wire load_bit = rate_ctrl_reg[`PEI_LOAD_BIT];
    wire t1_mode = mode_ctrl_reg[`PEI_T1_BIT];
    wire chsel_on = mode_ctrl_reg[`PEI_CHSEL_BIT];
    logic load_bit_d_reg;
    wire load_pulse = load_bit & ~load_bit_d_reg;

    // ----------------------------------------
    // Stream path
    // ----------------------------------------
    pei_bit_t fifo_bit;
    logic fifo_valid;
    pei_bit_t out_reg;
    logic out_valid_reg;
    pei_rate_t act_rate_reg;
    logic [17:0] bit_cnt_reg;

    wire stage_free = ~out_valid_reg | tx_out_ready;
    wire take = fifo_valid & stage_free;

    pei_fifo #(.WIDTH($bits(pei_bit_t)), .DEPTH(`PEI_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_data(tx_in),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .out_data(fifo_bit),
        .out_valid(fifo_valid),
        .out_ready(stage_free)
    );

    // New rate is picked up on the frame's first bit only
    wire pei_rate_t cur_rate = fifo_bit.frame_start ? rate_field : act_rate_reg;
    wire rate_change = fifo_bit.frame_start && rate_field != act_rate_reg;
    wire chan_ok = ~chsel_on | fifo_bit.chan_sel;
    wire counts = take & t1_mode & ~fifo_bit.fbit & chan_ok & (cur_rate != 4'h0);
    wire [17:0] cnt_base = rate_change ? 18'h00000 : bit_cnt_reg;
    wire at_end = counts && period_end(cnt_base, cur_rate);
    wire may_hit = const_mode | (left_reg != 10'h000);
    wire inject = at_end & may_hit;
    wire pei_count_t load_val = {cnt_hi_reg, cnt_lo_reg};

    // Rate period counter; restarts when a new rate lands
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_rate_reg <= 4'h0;
            bit_cnt_reg <= 18'h00000;
        end else if (take) begin
            act_rate_reg <= cur_rate;
            if (counts) bit_cnt_reg <= at_end ? 18'h00000 : 18'(cnt_base + 18'h00001);
            else if (rate_change) bit_cnt_reg <= 18'h00000;
        end
    end

    // Remaining count; a load in the same cycle as an insertion wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_bit_d_reg <= 1'b0;
            left_reg <= 10'h000;
        end else begin
            load_bit_d_reg <= load_bit;
            if (load_pulse) left_reg <= load_val;
            else if (inject & ~const_mode) left_reg <= 10'(left_reg - 10'h001);
        end
    end

    // Output stage; only the data bit is ever flipped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end else if (stage_free) begin
            out_valid_reg <= fifo_valid;
            if (fifo_valid) out_reg <= '{data: fifo_bit.data ^ inject, fbit: fifo_bit.fbit,
                frame_start: fifo_bit.frame_start, chan_sel: fifo_bit.chan_sel};
        end
    end

    assign tx_out = out_reg;
    assign tx_out_valid = out_valid_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_no_t1_pass: assert property (take && !t1_mode |=> tx_out.data == $past(fifo_bit.data))
        else $error("bit altered outside T1 mode");
    a_fbit_clean: assert property (take && fifo_bit.fbit |=> tx_out.data == $past(fifo_bit.data))
        else $error("framing bit inverted");
    a_rate_zero: assert property (take && cur_rate == 4'h0 |=> !$past(inject))
        else $error("error with zero rate");
    a_chan_skip: assert property (take && chsel_on && !fifo_bit.chan_sel |-> !inject)
        else $error("unselected channel corrupted");
    a_load_next: assert property ($rose(load_bit) |=> left_reg == $past(load_val))
        else $error("count not loaded one cycle after load edge");
    a_count_dec: assert property (inject && !const_mode && !load_pulse |=> left_reg == $past(left_reg) - 10'h001)
        else $error("remaining count did not step down");
    a_count_stop: assert property (!const_mode && left_reg == 10'h000 && !load_pulse |-> !inject)
        else $error("error inserted with none left");
    a_const_hold: assert property (const_mode && !load_pulse |=> $stable(left_reg))
        else $error("count moved in constant mode");
    a_rate_frame: assert property (take && !fifo_bit.frame_start |=> $stable(act_rate_reg))
        else $error("rate changed mid frame");
    a_sixteen_bits: assert property (inject && cur_rate == 4'h1 |-> cnt_base == 18'h0000f)
        else $error("1 in 16 hit at wrong bit");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // An insertion bit must really leave the block inverted,
    // otherwise the count would drop with no visible error
    a_inject_flip: assert property (take && inject |=> tx_out.data != $past(fifo_bit.data))
        else $error("insertion bit not inverted");

    // Every bit that is not an insertion passes unchanged,
    // so nothing outside the counted payload is ever hit
    a_plain_pass: assert property (take && !inject |=> tx_out.data == $past(fifo_bit.data))
        else $error("bit altered without insertion");

    // Once counted mode runs dry it stays dry until the next load;
    // a wrap to 1023 here would start a long unwanted burst
    a_left_hold: assert property (!const_mode && left_reg == 10'h000 && !load_pulse |=> left_reg == 10'h000)
        else $error("remaining count moved at zero");

    // Unused rate control bits never hold a one,
    // whatever software wrote into them
    a_rate_mask: assert property (rate_ctrl_reg[6:5] == 2'h0)
        else $error("unused rate bits set");

    // A held output bit must not change before the sink takes it,
    // or the formatter would see a different bit than was counted
    a_stall_hold: assert property (out_valid_reg && !tx_out_ready |=> tx_out_valid && $stable(tx_out))
        else $error("output bit changed while stalled");

    // An error answer carries no stale read data,
    // so software cannot mistake it for a register value
    a_err_zero: assert property (pslverr |-> prdata == 32'h00000000)
        else $error("read data with error answer");

    // The error flag only ever travels with the ready answer,
    // never on its own in an idle cycle
    a_err_pair: assert property (pslverr |-> pready)
        else $error("error flag without ready");

    // The frame's first bit picks up the rate held in the register,
    // which is the only point where the active rate may move
    a_frame_pick: assert property (take && fifo_bit.frame_start |=> act_rate_reg == $past(rate_field))
        else $error("rate not taken at frame start");

    // Any load edge wins over an insertion in the same cycle,
    // so the new count is never short by one
    a_load_wins: assert property (load_pulse |=> left_reg == $past(load_val))
        else $error("load lost to insertion");

    // Outside T1 mode nothing is inserted at all,
    // even if rate and count registers are still programmed
    a_t1_off_none: assert property (!t1_mode |-> !inject)
        else $error("insertion outside T1 mode");

    // Framing bits must not advance the period counter,
    // else the inverted bit would drift once per frame
    a_fbit_none: assert property (fifo_bit.fbit |-> !counts)
        else $error("framing bit counted");

    // Constant mode inserts at every period end,
    // whatever the remaining count says
    a_const_forever: assert property (const_mode && at_end |-> inject)
        else $error("constant mode skipped an error");

    // Unselected channels do not advance the period counter,
    // so the rate applies to the selected payload only
    a_chan_count: assert property (take && chsel_on && !fifo_bit.chan_sel |-> !counts)
        else $error("unselected channel counted");

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_counted_run: cover property (load_pulse ##[1:1000] inject);
    c_constant: cover property (const_mode && inject);
    c_rate_switch: cover property (take && rate_change);
    c_fifo_full: cover property (!tx_in_ready);
    c_chan_sel: cover property (take && chsel_on && inject);
endmodule
